// ### verilog/acev_top.sv
// comparator event logic: control, status flags, input-disable registers
// assumes comparator outputs arrive synchronous to pclk, apb master outside
`timescale 1ns/100ps
`default_nettype none

module acev_top (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [2:0] cmp_raw, // analog comparator outputs
    input wire logic cmp_clk_fall, // falling edge of comparator clock
    input wire logic clock_source_fuse, // fuse selects pll clock
    input wire logic [3:0] pin_raw, // neg, cmp2, cmp0, cmp1 pin levels
    output logic [3:0] pin_in, // gated pin inputs to port logic
    output logic [2:0] cmp_irq, // interrupt requests per comparator
    output logic [2:0] conv_trigger, // event flags for adc/dac triggering
    output logic [2:0] cmp_enable, // comparator enables
    output logic [8:0] cmp_negsel, // negative input code per comparator
    output logic cmp_clock_select // 1: divided pll clock
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] ctl [3];
    logic [2:0] cmp_sample;
    logic [2:0] event_flag;
    logic clk_sel;
    logic [7:0] dis_low;
    logic [7:0] dis_high;

    function automatic logic edge_hit(input logic [1:0] sense,
                                      input logic old_v,
                                      input logic new_v);
        case (sense)
            acev_pkg::acev_sense_toggle: edge_hit = old_v != new_v;
            acev_pkg::acev_sense_fall: edge_hit = old_v & ~new_v;
            acev_pkg::acev_sense_rise: edge_hit = ~old_v & new_v;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire logic wr_en = psel & penable & pwrite;
    wire logic hit_c0 = paddr == acev_pkg::OFF_CMP0_CONTROL;
    wire logic hit_c1 = paddr == acev_pkg::OFF_CMP1_CONTROL;
    wire logic hit_c2 = paddr == acev_pkg::OFF_CMP2_CONTROL;
    wire logic hit_st = paddr == acev_pkg::OFF_STATUS;
    wire logic hit_dl = paddr == acev_pkg::OFF_DIS_LOW;
    wire logic hit_dh = paddr == acev_pkg::OFF_DIS_HIGH;
    wire logic hit_va = paddr == acev_pkg::OFF_VECTOR_ACK;
    wire logic hit_any = hit_c0 | hit_c1 | hit_c2 | hit_st | hit_dl |
        hit_dh | hit_va;

    // ----------------------------------------------------------------
    // write strobes
    // ----------------------------------------------------------------
    wire logic wr_c0 = wr_en & hit_c0;
    wire logic wr_c1 = wr_en & hit_c1;
    wire logic wr_c2 = wr_en & hit_c2;
    wire logic wr_st = wr_en & hit_st;
    wire logic wr_dl = wr_en & hit_dl;
    wire logic wr_dh = wr_en & hit_dh;
    wire logic wr_va = wr_en & hit_va;

    // new comparison taken on falling comparator clock edge
    wire logic [2:0] next_sample = cmp_clk_fall ? cmp_raw : cmp_sample;
    wire logic [2:0] hit_edge;
    wire logic [2:0] sw_clear = wr_st ?
        pwdata[acev_pkg::STS_FLAG0 +: 3] : 3'h0;
    // vector entry: software acks the vector through its own word
    wire logic [2:0] vec_clear;
    wire logic [2:0] irq_en;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cmp
            assign hit_edge[gi] = cmp_clk_fall & ctl[gi][acev_pkg::CTL_ENABLE] &
                edge_hit(ctl[gi][acev_pkg::CTL_SENSE_HI:acev_pkg::CTL_SENSE_LO],
                         cmp_sample[gi], cmp_raw[gi]);
            assign irq_en[gi] = ctl[gi][acev_pkg::CTL_IRQ_ENABLE];
            assign vec_clear[gi] = wr_va & pwdata[gi] & irq_en[gi];
        end
    endgenerate

    // set wins over any clear
    wire logic [2:0] next_flag = hit_edge |
        (event_flag & ~sw_clear & ~vec_clear);

    wire logic [7:0] ctl_wdata = pwdata[7:0];
    wire logic next_clk_sel = wr_st ?
        pwdata[acev_pkg::STS_CLOCK_SELECT] : clk_sel;
    wire logic clk_sel_view = clk_sel | clock_source_fuse;

    wire logic [7:0] status_view = {1'b0, event_flag, clk_sel_view,
        cmp_sample};

    wire logic [7:0] rd_mux =
        hit_c0 ? ctl[0] :
        hit_c1 ? ctl[1] :
        hit_c2 ? ctl[2] :
        hit_st ? status_view :
        hit_dl ? dis_low :
        hit_dh ? (dis_high & acev_pkg::DIS_HIGH_MASK) : 8'h00;

    wire logic [3:0] next_pin_in = {
        pin_raw[3] & ~dis_low[acev_pkg::DIS_NEG_PIN],
        pin_raw[2] & ~dis_low[acev_pkg::DIS_CMP2_PIN],
        pin_raw[1] & ~dis_high[acev_pkg::DIS_CMP0_PIN],
        pin_raw[0] & ~dis_high[acev_pkg::DIS_CMP1_PIN]};

    // ----------------------------------------------------------------
    // next values of registers and outputs
    // ----------------------------------------------------------------
    wire logic [7:0] next_ctl0 = wr_c0 ?
        (ctl_wdata & acev_pkg::CTL0_MASK) : ctl[0];
    wire logic [7:0] next_ctl1 = wr_c1 ?
        (ctl_wdata & acev_pkg::CTL1_MASK) : ctl[1];
    wire logic [7:0] next_ctl2 = wr_c2 ?
        (ctl_wdata & acev_pkg::CTL2_MASK) : ctl[2];
    wire logic [7:0] next_dis_low = wr_dl ? ctl_wdata : dis_low;
    wire logic [7:0] next_dis_high = wr_dh ?
        (ctl_wdata & acev_pkg::DIS_HIGH_MASK) : dis_high;
    wire logic [2:0] next_irq = next_flag & irq_en;
    wire logic [2:0] next_enable = {ctl[2][acev_pkg::CTL_ENABLE],
        ctl[1][acev_pkg::CTL_ENABLE], ctl[0][acev_pkg::CTL_ENABLE]};
    wire logic [8:0] next_negsel = {ctl[2][2:0], ctl[1][2:0], ctl[0][2:0]};
    wire logic next_clock_select = next_clk_sel | clock_source_fuse;
    // answer prepared in setup so it stands during the access cycle
    wire logic in_setup = psel & ~penable;
    wire logic next_pslverr = in_setup & ~hit_any;
    wire logic [31:0] next_prdata = (in_setup & ~pwrite) ?
        {24'h00_0000, rd_mux} : 32'h0000_0000;

    // ----------------------------------------------------------------
    // control and input-disable registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl[0] <= acev_pkg::CTL_RESET;
            ctl[1] <= acev_pkg::CTL_RESET;
            ctl[2] <= acev_pkg::CTL_RESET;
        end else begin
            ctl[0] <= next_ctl0;
            ctl[1] <= next_ctl1;
            ctl[2] <= next_ctl2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dis_low <= acev_pkg::DIS_LOW_RESET;
        end else begin
            dis_low <= next_dis_low;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dis_high <= acev_pkg::DIS_HIGH_RESET;
        end else begin
            dis_high <= next_dis_high;
        end
    end

    // ----------------------------------------------------------------
    // samples, flags, clock select
    // ----------------------------------------------------------------
    // sample held between comparator clock edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_sample <= 3'h0;
        end else begin
            cmp_sample <= next_sample;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_flag <= 3'h0;
        end else begin
            event_flag <= next_flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sel <= 1'b0;
        end else begin
            clk_sel <= next_clk_sel;
        end
    end

    // ----------------------------------------------------------------
    // flag outputs
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_irq <= 3'h0;
        end else begin
            cmp_irq <= next_irq;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_trigger <= 3'h0;
        end else begin
            conv_trigger <= next_flag;
        end
    end

    // ----------------------------------------------------------------
    // configuration outputs
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_enable <= 3'h0;
        end else begin
            cmp_enable <= next_enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_negsel <= 9'h000;
        end else begin
            cmp_negsel <= next_negsel;
        end
    end

    // fuse forces the divided pll clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_clock_select <= 1'b0;
        end else begin
            cmp_clock_select <= next_clock_select;
        end
    end

    // disabled pins read zero at the port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_in <= 4'h0;
        end else begin
            pin_in <= next_pin_in;
        end
    end

    // ----------------------------------------------------------------
    // apb answer
    // ----------------------------------------------------------------
    // only the low byte carries data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    // zero wait states: ready follows each setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= in_setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= next_pslverr;
        end
    end
endmodule : acev_top

`default_nettype wire

// ### verilog/acev_pkg.sv
// package: register map, field positions and codes of the comparator logic
// assumes an apb slave with 32-bit data, one register per aligned word
package acev_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CMP0_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CMP1_CONTROL = 8'h04;
    localparam logic [7:0] OFF_CMP2_CONTROL = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_DIS_LOW = 8'h10;
    localparam logic [7:0] OFF_DIS_HIGH = 8'h14;
    localparam logic [7:0] OFF_VECTOR_ACK = 8'h18;
    // control fields
    localparam int CTL_ENABLE = 7;
    localparam int CTL_IRQ_ENABLE = 6;
    localparam int CTL_SENSE_HI = 5;
    localparam int CTL_SENSE_LO = 4;
    localparam int CTL_CAPTURE = 3;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL0_MASK = 8'hf7;
    localparam logic [7:0] CTL1_MASK = 8'hff;
    localparam logic [7:0] CTL2_MASK = 8'hf7;
    // status fields
    localparam int STS_FLAG0 = 4;
    localparam int STS_CLOCK_SELECT = 3;
    localparam int STS_OUT0 = 0;
    // input disable fields
    localparam int DIS_NEG_PIN = 3;
    localparam int DIS_CMP2_PIN = 2;
    localparam int DIS_CMP0_PIN = 5;
    localparam int DIS_CMP1_PIN = 2;
    localparam logic [7:0] DIS_LOW_RESET = 8'h00;
    localparam logic [7:0] DIS_HIGH_RESET = 8'h00;
    localparam logic [7:0] DIS_HIGH_MASK = 8'h3f;
    // sensitivity codes
    typedef enum logic [1:0] {
        acev_sense_toggle = 2'h0,
        acev_sense_reserved = 2'h1,
        acev_sense_fall = 2'h2,
        acev_sense_rise = 2'h3
    } acev_sense_t;
    // negative input codes
    typedef enum logic [2:0] {
        acev_neg_div640 = 3'h0,
        acev_neg_div320 = 3'h1,
        acev_neg_div213 = 3'h2,
        acev_neg_div160 = 3'h3,
        acev_neg_pin = 3'h4,
        acev_neg_dac = 3'h5,
        acev_neg_res6 = 3'h6,
        acev_neg_res7 = 3'h7
    } acev_negsel_t;
endpackage : acev_pkg

// ### tb/acev_checker.sv
// checker: bus timing and event flag relations at the block's ports
// assumes a bind onto acev_top from the bench top file
`timescale 1ns/100ps
`default_nettype none
module acev_checker (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // select
    input wire logic penable, // access phase
    input wire logic pwrite, // direction
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic cmp_clk_fall, // comparator sample pulse
    input wire logic [3:0] pin_raw, // raw pins
    input wire logic [3:0] pin_in, // gated pins
    input wire logic [2:0] cmp_irq, // irq requests
    input wire logic [2:0] conv_trigger, // event flags
    input wire logic [2:0] cmp_enable // comparator enables
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle: assert property (prdata != 32'h0 |-> pready)
        else $error("read data outside access phase");
    a_irq_flag: assert property ((cmp_irq & ~conv_trigger) == 3'h0)
        else $error("irq without its flag");
    a_pin_gate: assert property ((pin_in & ~$past(pin_raw)) == 4'h0)
        else $error("gated pin high without raw level");
    a_flag_cause: assert property ((conv_trigger & ~$past(conv_trigger)
        & ~$past({3{cmp_clk_fall}} & cmp_enable)) == 3'h0)
        else $error("flag set without enabled sample");
    a_flag_clear: assert property ((($past(conv_trigger) & ~conv_trigger)
        != 3'h0) |-> $past(psel && penable && pwrite))
        else $error("flag cleared without a write");
endmodule : acev_checker
`default_nettype wire

// ### tb/acev_top_tb.sv
// bench: random and corner stimulus of the comparator event logic
// assumes acev_pkg and acev_top compiled before, checker beside
`timescale 1ns/100ps
`default_nettype none
module acev_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic cmp_clk_fall = 0, clock_source_fuse = 0, pslv;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, r;
    logic [2:0] cmp_raw = 0, b, ns;
    logic [3:0] pin_raw = 0, pr;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, cmp_clock_select;
    wire logic [3:0] pin_in;
    wire logic [2:0] cmp_irq, conv_trigger, cmp_enable;
    wire logic [8:0] cmp_negsel;
    int err_count = 0, check_count = 0, seed = 32'h62e6;
    acev_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cmp_raw, .cmp_clk_fall,
        .clock_source_fuse, .pin_raw, .pin_in, .cmp_irq, .conv_trigger,
        .cmp_enable, .cmp_negsel, .cmp_clock_select);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", pready, 1'b1);
        r = prdata;
        pslv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic ev(input logic [2:0] v);
        cmp_raw <= v;
        cmp_clk_fall <= 1'b1;
        @(posedge pclk);
        cmp_clk_fall <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : ev
    function automatic logic ex(logic [1:0] s, logic o, logic nw);
        case (s)
            2'h0: ex = o != nw;
            2'h2: ex = o & !nw;
            2'h3: ex = !o & nw;
            default: ex = 1'b0;
        endcase
    endfunction : ex
    initial forever #50 pclk = ~pclk;
    initial begin
        #2000000;
        err_count++;
        print_verdict;
    end
    initial begin
        logic o, nw, e;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check("reset value", r, 32'h0);
        end
        apb(1'b0, 8'h1c, 32'h0);
        check("unmapped err", pslv, 1'b1);
        check("unmapped data", r, 32'h0);
        apb(1'b1, acev_pkg::OFF_DIS_HIGH, 32'hff);
        apb(1'b0, acev_pkg::OFF_DIS_HIGH, 32'h0);
        check("dis high", r, 32'h3f);
        pr = 4'($random(seed));
        pin_raw <= pr;
        repeat (2) @(posedge pclk);
        check("pins high off", pin_in, pr & 4'hc);
        apb(1'b1, acev_pkg::OFF_DIS_HIGH, 32'h0);
        apb(1'b1, acev_pkg::OFF_DIS_LOW, 32'h0c);
        @(posedge pclk);
        check("pins low off", pin_in, pr & 4'h3);
        clock_source_fuse <= 1'b1;
        apb(1'b0, acev_pkg::OFF_STATUS, 32'h0);
        check("fuse clock", r[3], 1'b1);
        check("fuse clock pin", cmp_clock_select, 1'b1);
        clock_source_fuse <= 1'b0;
        apb(1'b1, acev_pkg::OFF_STATUS, 32'h08);
        apb(1'b0, acev_pkg::OFF_STATUS, 32'h0);
        check("clock select", r[3], 1'b1);
        check("clock select pin", cmp_clock_select, 1'b1);
        for (int c = 0; c < 3; c++) for (int s = 0; s < 4; s++)
        for (int k = 0; k < 4; k++) begin
            o = k[0];
            nw = k[1];
            ns = 3'($unsigned($random(seed)) % 6);
            apb(1'b1, 8'(4 * c), 32'h80 | 32'(s << 4) | 32'(ns));
            b = 3'($random(seed));
            b[c] = o;
            ev(b);
            ev(b);
            apb(1'b1, acev_pkg::OFF_STATUS, 32'h70);
            b[c] = nw;
            ev(b);
            e = ex(2'(s), o, nw);
            apb(1'b0, acev_pkg::OFF_STATUS, 32'h0);
            check("flag", r[4 + c], e);
            check("output", r[c], nw);
            check("trigger", conv_trigger[c], e);
            check("negsel", cmp_negsel[3 * c +: 3], ns);
            apb(1'b1, acev_pkg::OFF_STATUS, 32'h0);
            check("flag kept", conv_trigger[c], e);
            apb(1'b1, acev_pkg::OFF_STATUS, 32'h70);
            check("flag cleared", conv_trigger[c], 1'b0);
        end
        apb(1'b1, acev_pkg::OFF_CMP0_CONTROL, 32'hc0);
        apb(1'b1, acev_pkg::OFF_CMP1_CONTROL, 32'h80);
        apb(1'b1, acev_pkg::OFF_CMP2_CONTROL, 32'h40);
        ev(3'h7);
        apb(1'b1, acev_pkg::OFF_STATUS, 32'h70);
        ev(3'h0);
        check("irq", cmp_irq, 3'h1);
        check("enables", cmp_enable, 3'h3);
        check("enabled only", conv_trigger, 3'h3);
        apb(1'b1, acev_pkg::OFF_VECTOR_ACK, 32'h3);
        check("vector clear", conv_trigger, 3'h2);
        fork
            apb(1'b1, acev_pkg::OFF_STATUS, 32'h70);
            begin
                @(posedge pclk);
                cmp_raw <= 3'h1;
                cmp_clk_fall <= 1'b1;
                @(posedge pclk);
                cmp_clk_fall <= 1'b0;
            end
        join
        check("set beats clear", conv_trigger, 3'h1);
        print_verdict;
    end
endmodule : acev_top_tb
bind acev_top acev_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .cmp_clk_fall, .pin_raw, .pin_in, .cmp_irq,
    .conv_trigger, .cmp_enable);
`default_nettype wire
